/* hw/npx_page_ecc.sv */
// page xor ecc generator and checker
`timescale 1ns/1ns
module npx_page_ecc (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic page_start_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_data_i,
  input wire logic check_i,
  input wire logic [npx_pkg::NPX_CODE_W-1:0] stored_code_i,
  output logic [npx_pkg::NPX_CODE_W-1:0] new_code_o,
  output logic page_done_o,
  output logic result_valid_o,
  output logic [npx_pkg::NPX_CODE_W-1:0] syndrome_o,
  output logic [3:0] result_o,
  output logic [2:0] err_bit_o,
  output logic [8:0] err_byte_o
);
  import npx_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NPX_ROW_LEVELS-1:0] idx;
    logic [NPX_CODE_W-1:0] code;
    logic done;
    logic rvalid;
    logic [NPX_CODE_W-1:0] synd;
    logic [3:0] res;
    logic [2:0] ebit;
    logic [8:0] ebyte;
  } npx_state_t;

  npx_state_t st;
  npx_state_t next_st;

  logic [2:0] bt;
  logic [2:0] bc;
  logic bp;
  logic [NPX_CODE_W-1:0] pc;
  logic [NPX_CODE_W-1:0] acc;
  logic [NPX_CODE_W-1:0] sy;
  logic all_ok;
  logic any_set;
  logic [2:0] eb;
  logic [8:0] ey;
  logic [NPX_ROW_LEVELS-1:0] cur_idx;

  // ****************************************
  // byte parities
  // ****************************************
  always_comb begin
    // a byte that comes with the start strobe is byte zero, whatever index a cut page left
    cur_idx = page_start_i ? '0 : st.idx;
    bt[0] = ^(byte_data_i & NPX_MASK_LO);
    bt[1] = ^(byte_data_i & NPX_MASK_MID);
    bt[2] = ^(byte_data_i & NPX_MASK_HI);
    bc[0] = ^(byte_data_i & ~NPX_MASK_LO);
    bc[1] = ^(byte_data_i & ~NPX_MASK_MID);
    bc[2] = ^(byte_data_i & ~NPX_MASK_HI);
    bp = ^byte_data_i;
    pc = '0;
    for (int k = 0; k < NPX_COL_LEVELS; k++) begin
      pc[2*k+1] = bt[k];
      pc[2*k] = bc[k];
    end
    // whole-byte parity goes to true or comp row by index bit
    for (int k = 0; k < NPX_ROW_LEVELS; k++) begin
      pc[NPX_ROW_BASE+2*k+1] = bp & cur_idx[k];
      pc[NPX_ROW_BASE+2*k] = bp & ~cur_idx[k];
    end
  end

  // ****************************************
  // syndrome decode on the finished code
  // ****************************************
  always_comb begin
    acc = (page_start_i ? '0 : st.code) ^ pc;
    sy = stored_code_i ^ st.code;
    all_ok = 1'b1;
    any_set = |sy;
    eb = '0;
    ey = '0;
    for (int k = 0; k < NPX_CODE_W/2; k++) begin
      if (sy[2*k+:2] != NPX_PAIR_ONE && sy[2*k+:2] != NPX_PAIR_ZERO) begin
        all_ok = 1'b0;
      end
    end
    for (int k = 0; k < NPX_COL_LEVELS; k++) begin
      eb[k] = (sy[2*k+:2] == NPX_PAIR_ONE);
    end
    for (int k = 0; k < NPX_ROW_LEVELS; k++) begin
      ey[k] = (sy[NPX_ROW_BASE+2*k+:2] == NPX_PAIR_ONE);
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.rvalid = 1'b0;
    if (page_start_i) begin
      next_st.idx = '0;
      next_st.code = '0;
    end
    if (byte_valid_i) begin
      next_st.code = acc;
      next_st.idx = cur_idx + 9'h001;
      next_st.done = (cur_idx == NPX_LAST_BYTE);
    end
    // check uses the code as it stands; issue after page_done_o
    if (check_i) begin
      next_st.rvalid = 1'b1;
      next_st.synd = sy;
      next_st.ebit = '0;
      next_st.ebyte = '0;
      if (!any_set) begin
        next_st.res = NPX_RES_NONE;
      end else if (all_ok) begin
        next_st.res = NPX_RES_CODE;
        next_st.ebit = eb;
        next_st.ebyte = ey;
      end else if (sy == (sy & -sy)) begin
        // a single flipped bit in the stored code itself
        next_st.res = NPX_RES_ONE;
      end else begin
        next_st.res = NPX_RES_MULTI;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '{idx: '0, code: '0, done: 1'b0, rvalid: 1'b0, synd: '0,
              res: NPX_RES_NONE, ebit: '0, ebyte: '0};
    end else begin
      st <= next_st;
    end
  end

  assign new_code_o = st.code;
  assign page_done_o = st.done;
  assign result_valid_o = st.rvalid;
  assign syndrome_o = st.synd;
  assign result_o = st.res;
  assign err_bit_o = st.ebit;
  assign err_byte_o = st.ebyte;

  // ****************************************
  // checks
  // ****************************************
  chk_col_hi_pair: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    byte_valid_i && !page_start_i |=> new_code_o[5] == $past(st.code[5] ^ (^byte_data_i[7:4])))
    else $error("high column parity wrong");
  chk_col_lo_comp: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    byte_valid_i && page_start_i |=> new_code_o[0] == $past(^{byte_data_i[6], byte_data_i[4],
      byte_data_i[2], byte_data_i[0]}))
    else $error("low comp parity wrong");
  chk_mid_true: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    byte_valid_i && page_start_i |=> new_code_o[3] == $past(^{byte_data_i[7:6], byte_data_i[3:2]}))
    else $error("mid true parity wrong");
  chk_synd_xor: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    check_i |=> syndrome_o == $past(stored_code_i ^ new_code_o))
    else $error("syndrome not xor of codes");
  chk_row_top: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    byte_valid_i && !page_start_i && st.idx[8] |=> new_code_o[23] == $past(st.code[23] ^ (^byte_data_i)))
    else $error("top row parity wrong");
  chk_bit_decode: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    result_valid_o && result_o == NPX_RES_CODE |-> err_bit_o[2] == (syndrome_o[5:4] == NPX_PAIR_ONE))
    else $error("bit decode wrong");
  chk_byte_report: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    result_valid_o && result_o == NPX_RES_CODE |-> err_byte_o[0] == syndrome_o[7])
    else $error("byte index wrong");
  chk_page_end: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    page_done_o |-> $past(byte_valid_i) && st.idx == '0)
    else $error("page end misplaced");
  // running code, one byte at a time
  chk_start_row: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    byte_valid_i && page_start_i |=> !new_code_o[23] && new_code_o[22] == $past(^byte_data_i))
    else $error("first byte not in low rows");
  chk_col_lo_true: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    byte_valid_i && !page_start_i |=> new_code_o[1] == $past(st.code[1] ^
      (^{byte_data_i[7], byte_data_i[5], byte_data_i[3], byte_data_i[1]})))
    else $error("low column parity wrong");
  chk_col_hi_comp: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    byte_valid_i && !page_start_i |=> new_code_o[4] == $past(st.code[4] ^ (^byte_data_i[3:0])))
    else $error("high comp parity wrong");
  chk_row_top_comp: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    byte_valid_i && !page_start_i && !st.idx[8] |=> new_code_o[22] == $past(st.code[22] ^ (^byte_data_i)))
    else $error("top row comp parity wrong");
  // a byte taken twice would show here as a code that moves while idle
  chk_idle_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !byte_valid_i && !page_start_i |=> $stable(new_code_o))
    else $error("code moved without a byte");
  chk_done_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    page_done_o |=> !page_done_o)
    else $error("page done longer than one cycle");
  // check and report
  chk_valid_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    check_i |=> result_valid_o)
    else $error("no result after check");
  chk_result_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !check_i |=> $stable(result_o) && $stable(syndrome_o))
    else $error("result changed without check");
  chk_clean_none: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    result_valid_o && syndrome_o == '0 |-> result_o == NPX_RES_NONE)
    else $error("clean syndrome not reported clean");
  chk_report_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    result_valid_o && result_o != NPX_RES_CODE |-> err_bit_o == '0 && err_byte_o == '0)
    else $error("location reported without correctable error");
  // ****************************************
  // cover points
  // ****************************************
  cov_clean: cover property (@(posedge ref_clk_i) result_valid_o && result_o == NPX_RES_NONE);
  cov_single: cover property (@(posedge ref_clk_i) result_valid_o && result_o == NPX_RES_ONE);
  cov_fix: cover property (@(posedge ref_clk_i) result_valid_o && result_o == NPX_RES_CODE);
  cov_multi: cover property (@(posedge ref_clk_i) result_valid_o && result_o == NPX_RES_MULTI);
  cov_page: cover property (@(posedge ref_clk_i) page_done_o);
endmodule

/* hw/npx_pkg.sv */
// constants and types for the page xor ecc block
//
// Notes on behaviour
// - true byte parities: 7654, 7632, 7531
// - complementary byte parities: 3210, 5410, 6420
// - syndrome is stored code xor new code
// - pair 10 gives one, 01 gives zero
// - column parities xor byte parities over page
// - row parities split bytes by index bits
package npx_pkg;
  // ****************************************
  // page geometry
  // ****************************************
  localparam int NPX_ROW_LEVELS = 9;
  localparam int NPX_COL_LEVELS = 3;
  localparam int NPX_CODE_W = 2 * (NPX_ROW_LEVELS + NPX_COL_LEVELS);
  localparam logic [NPX_ROW_LEVELS-1:0] NPX_LAST_BYTE = 9'h1FF;
  // ****************************************
  // code layout: pair k at bits 2k+1 (true), 2k (comp); col pairs low
  // ****************************************
  localparam int NPX_ROW_BASE = 2 * NPX_COL_LEVELS;
  localparam logic [1:0] NPX_PAIR_ONE = 2'h2;
  localparam logic [1:0] NPX_PAIR_ZERO = 2'h1;
  localparam logic [1:0] NPX_PAIR_NONE = 2'h0;
  // bit masks for true parities per level, lo/mid/hi
  localparam logic [7:0] NPX_MASK_LO = 8'hAA;
  localparam logic [7:0] NPX_MASK_MID = 8'hCC;
  localparam logic [7:0] NPX_MASK_HI = 8'hF0;
  // result classes
  typedef enum logic [3:0] {
    NPX_RES_NONE = 4'h1,
    NPX_RES_ONE = 4'h2,
    NPX_RES_CODE = 4'h4,
    NPX_RES_MULTI = 4'h8
  } npx_result_t;
endpackage

/* sim/npx_nand_src.sv */
// nand datapath model streaming one page of bytes
`timescale 1ns/1ns
module npx_nand_src (
  input wire logic ref_clk_i,
  input wire logic go_i,
  input wire logic gap_i,
  input wire logic [3:0] flip_bit_i,
  input wire logic [8:0] flip_byte_i,
  output logic page_start_o,
  output logic byte_valid_o,
  output logic [7:0] byte_data_o
);
  int idx = 512;
  bit g;
  bit slow;
  initial begin
    page_start_o = 1'b0;
    byte_valid_o = 1'b0;
    byte_data_o = 8'h00;
  end
  // idle data toggles so a stale byte never looks like the last one
  always @(posedge ref_clk_i) begin
    g = go_i;
    #1;
    if (g) idx = 0;
    slow = gap_i & ~slow;
    if (idx < 512 && !slow) begin
      page_start_o = (idx == 0);
      byte_valid_o = 1'b1;
      byte_data_o = 8'(idx * 37 + 11) ^ ((flip_bit_i[3] && idx == flip_byte_i) ? 8'h01 << flip_bit_i[2:0] : 8'h00);
      idx++;
    end else begin
      page_start_o = 1'b0;
      byte_valid_o = 1'b0;
      byte_data_o = ~byte_data_o;
    end
  end
endmodule

/* sim/npx_page_ecc_tb_top.sv */
// self-checking bench for the page xor ecc block
`timescale 1ns/1ns
module npx_page_ecc_tb_top;
  import npx_pkg::*;
  typedef struct {logic [3:0] fb; logic [8:0] fy; logic gap; logic [23:0] cx; logic [3:0] res;} npx_row_t;
  logic ref_clk_i = 1'b0, reset_i = 1'b1, check_i = 1'b0, go = 1'b0, gap = 1'b0;
  logic [3:0] fbit = 4'h0;
  logic [8:0] fbyte = 9'h000;
  logic [23:0] stored = 24'h000000, new_code, syn;
  logic ps, bv, done, rv;
  logic [7:0] bd;
  logic [3:0] res;
  logic [2:0] ebit;
  logic [8:0] ebyte;
  int fail_count = 0, check_count = 0;
  logic [7:0] mk [3] = '{NPX_MASK_LO, NPX_MASK_MID, NPX_MASK_HI};
  npx_row_t rows [6] = '{'{4'h0, 9'h000, 1'b0, 24'h000000, 4'h1}, '{4'hF, 9'h1FF, 1'b0, 24'h000000, 4'h4},
    '{4'h8, 9'h000, 1'b1, 24'h000000, 4'h4}, '{4'hD, 9'h0A5, 1'b1, 24'h000000, 4'h4},
    '{4'h0, 9'h000, 1'b0, 24'h000010, 4'h2}, '{4'hA, 9'h003, 1'b0, 24'h000001, 4'h8}};
  always #2 ref_clk_i = ~ref_clk_i;
  npx_nand_src npx_nand_src_inst (.ref_clk_i(ref_clk_i), .go_i(go), .gap_i(gap), .flip_bit_i(fbit),
    .flip_byte_i(fbyte), .page_start_o(ps), .byte_valid_o(bv), .byte_data_o(bd));
  npx_page_ecc npx_page_ecc_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .page_start_i(ps),
    .byte_valid_i(bv), .byte_data_i(bd), .check_i(check_i), .stored_code_i(stored), .new_code_o(new_code),
    .page_done_o(done), .result_valid_o(rv), .syndrome_o(syn), .result_o(res), .err_bit_o(ebit),
    .err_byte_o(ebyte));
  function automatic logic [23:0] ref_code(input logic [3:0] fb, input logic [8:0] fy);
    logic [23:0] c;
    logic [7:0] d;
    c = 24'h000000;
    for (int i = 0; i < 512; i++) begin
      d = 8'(i * 37 + 11) ^ ((fb[3] && i == fy) ? 8'h01 << fb[2:0] : 8'h00);
      for (int k = 0; k < 3; k++) begin
        c[2*k+1] ^= ^(d & mk[k]);
        c[2*k] ^= ^(d & ~mk[k]);
      end
      for (int r = 0; r < 9; r++) c[2*r+6+((i>>r)&1)] ^= ^d;
    end
    return c;
  endfunction
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic run_row(input npx_row_t r);
    logic [23:0] nc;
    nc = ref_code(r.fb, r.fy);
    fbit = r.fb;
    fbyte = r.fy;
    gap = r.gap;
    stored = ref_code(4'h0, 9'h000) ^ r.cx;
    go = 1'b1;
    @(posedge ref_clk_i);
    #1 go = 1'b0;
    for (int t = 0; t < 1200 && done !== 1'b1; t++) begin
      @(posedge ref_clk_i);
      #1;
    end
    if (done !== 1'b1) begin
      fail_count++;
      $display("[FAIL] page done expected 1 seen %b", done);
      return;
    end
    chk("code", nc, new_code);
    check_i = 1'b1;
    @(posedge ref_clk_i);
    #1 check_i = 1'b0;
    chk("valid", 24'h000001, 24'(rv));
    chk("done pulse", 24'h000000, 24'(done));
    chk("syndrome", stored ^ nc, syn);
    chk("result", 24'(r.res), 24'(res));
    chk("bit", r.res == 4'h4 ? 24'(r.fb[2:0]) : 24'h0, 24'(ebit));
    chk("byte", r.res == 4'h4 ? 24'(r.fy) : 24'h0, 24'(ebyte));
    @(posedge ref_clk_i);
    #1;
    chk("valid drop", 24'h000000, 24'(rv));
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (20) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    chk("reset result", 24'h000001, 24'(res));
    foreach (rows[n]) run_row(rows[n]);
    // restart in mid page: the byte that comes with the start strobe is byte zero
    go = 1'b1;
    @(posedge ref_clk_i);
    #1 go = 1'b0;
    repeat (40) @(posedge ref_clk_i);
    #1;
    run_row(rows[1]);
    // reset in mid page, held until the stream has run out
    go = 1'b1;
    @(posedge ref_clk_i);
    #1 go = 1'b0;
    repeat (100) @(posedge ref_clk_i);
    #1 reset_i = 1'b1;
    repeat (450) @(posedge ref_clk_i);
    #1;
    chk("reset code", 24'h000000, new_code);
    chk("reset syndrome", 24'h000000, syn);
    chk("reset result", 24'h000001, 24'(res));
    reset_i = 1'b0;
    run_row(rows[3]);
    end_of_test;
  end
endmodule
